// ### hdl/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// What this block does
// - serial clock shifts data and runs conversion
// - control bit 1 picks single or double span
// - range bit 1 gives 0..ref, 0 gives 0..2ref
// - control bit 0 picks binary or twos complement
// - one code step is reference over 4096 in single span, twice that in double span
// - twos complement double span centres zero on reference
// - each word carries channel tag then result
// - address bits pick channel outside sequencing
// - sequence steps once per frame
// - mask sequence starts lowest channel, ascends
// - after highest masked channel wrap to lowest
// - mode write 1,0 keeps sequence, 0,0 stops it
// - mode 1,1 runs channel 0 up to address
// - consecutive run restarts at channel 0
// - mask loads on frame after mode 0,1 write
// - control loads from first 12 bits when write set, except in the mask frame
// - mode 0,0 converts addressed channel each frame
`define ACS_DATA_BITS 12
`define ACS_CHANNELS 16
`define ACS_CTL_WRITE 11
`define ACS_CTL_AUTO 10
`define ACS_CTL_ADDR_HI 9
`define ACS_CTL_ADDR_LO 6
`define ACS_CTL_PM_HI 5
`define ACS_CTL_PM_LO 4
`define ACS_CTL_SHADOW 3
`define ACS_CTL_RANGE 1
`define ACS_CTL_CODING 0
`define ACS_CTL_RESET 12'h000
`define ACS_MASK_RESET 16'h0000
`define ACS_CONV_RESET 2'h0
`define ACS_CFG_RESET 1'h1
`define ACS_CFG_EN_BIT 0
`define ACS_CNT_SAR_START 4'h1
`define ACS_CNT_SAR_LAST 4'hD
`define ACS_CNT_CTRL_DONE 4'hB
`define ACS_CNT_HOLD_END 4'hE
`define ACS_CNT_LAST 4'hF
`define ACS_MSB_FLIP 12'h800
`define ACS_REG_CFG 5'h00
`define ACS_REG_RESULT 5'h04
`define ACS_REG_CTRL 5'h08
`define ACS_REG_MASK 5'h0C
`define ACS_REG_STATUS 5'h10
`endif

// ### hdl/acs_pkg.sv
package acs_pkg;
    typedef enum logic [1:0] {SEQ_OFF, SEQ_LOAD_MASK, SEQ_MASK, SEQ_CONSEC} acs_seq_state_t;
    // order follows the {auto cycle, shadow} bit pair
    typedef enum logic [1:0] {MODE_PLAIN, MODE_MASK_NEXT, MODE_KEEP, MODE_CONSEC} acs_mode_t;
endpackage : acs_pkg

// ### hdl/acs_sync2.sv
`timescale 1ns/10ps

module acs_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    if (WIDTH < 1) begin : g_chk
        $error("acs_sync2: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
    end

    assign sync_o = sync_reg;
endmodule : acs_sync2

// ### hdl/acs_sar.sv
`timescale 1ns/10ps
`include "acs_map.svh"

module acs_sar #(
    parameter int BITS = `ACS_DATA_BITS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic start_i,
    input wire logic step_i,
    input wire logic comp_i,
    output logic [BITS-1:0] code_o
);
    localparam logic [BITS-1:0] MSB = {1'b1, {(BITS-1){1'b0}}};
    logic [BITS-1:0] code_reg;
    logic [BITS-1:0] trial_reg;

    if (BITS < 2) begin : g_chk
        $error("acs_sar: BITS must be at least 2");
    end

    // one decision per serial clock, no other timebase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_reg <= '0;
            trial_reg <= '0;
        end else if (en_i && start_i) begin
            code_reg <= MSB;
            trial_reg <= MSB;
        end else if (en_i && step_i) begin
            code_reg <= (comp_i ? code_reg : code_reg & ~trial_reg) | (trial_reg >> 1);
            trial_reg <= trial_reg >> 1;
        end
    end

    assign code_o = code_reg;

    sar_start_a:
        assert property (@(posedge clk_i) disable iff (rst_i)
            en_i && start_i |=> code_reg == MSB && trial_reg == MSB)
        else $error("conversion did not start at mid scale");

    sar_drop_a:
        assert property (@(posedge clk_i) disable iff (rst_i)
            en_i && step_i && !start_i && !comp_i && trial_reg == MSB
            |=> !code_reg[BITS-1] && code_reg[BITS-2])
        else $error("rejected trial bit was kept");
endmodule : acs_sar

// ### hdl/acs_adc_seq.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "acs_map.svh"

module acs_adc_seq #(
    parameter int DATA_BITS = `ACS_DATA_BITS,
    parameter int CHANNELS = `ACS_CHANNELS
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sclk_i,
    input wire logic frame_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    input wire logic comp_i,
    output logic [3:0] mux_sel_o,
    output logic [DATA_BITS-1:0] dac_code_o,
    output logic span_double_o,
    output logic hold_o,
    output logic [1:0] power_mode_o
);
    if (DATA_BITS != `ACS_DATA_BITS || CHANNELS != `ACS_CHANNELS) begin : g_chk
        $error("acs_adc_seq: only 12 data bits and 16 channels are served");
    end

    // system side state
    logic cfg_en_reg;
    logic ack_reg;
    logic req;
    logic [31:0] rdata_reg;
    logic tog_s;
    logic tog_seen_reg;
    logic [15:0] res_reg;
    logic [11:0] ctrl_s_reg;
    logic [15:0] mask_s_reg;
    logic [1:0] seq_s_reg;
    logic [15:0] frames_reg;
    logic run_src;

    // link side state
    logic link_clk;
    logic link_rst;
    logic link_run;
    logic [1:0] to_link;
    logic active;
    logic [3:0] count_reg;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [11:0] ctrl_word;
    logic [11:0] ctrl_reg;
    logic wrote_reg;
    logic [15:0] mask_reg;
    logic [15:0] mask_in;
    logic [3:0] chan_reg;
    logic [3:0] step_chan;
    logic [3:0] addr;
    acs_pkg::acs_mode_t mode;
    acs_pkg::acs_seq_state_t seq_reg;
    logic ctrl_edge;
    logic frame_end;
    logic sar_start;
    logic sar_step;
    logic [11:0] code;
    logic [11:0] coded;
    logic [15:0] out_word;
    logic [15:0] word_hold_reg;
    logic tog_reg;
    logic [1:0] conv_cfg_reg;

    // sampling on the falling serial edge
    assign link_clk = ~sclk_i;
    // gating a running frame mid-word corrupts it
    assign run_src = cfg_en_reg & ce_i;

    acs_sync2 #(
        .WIDTH(2)
    ) u_to_link (
        .clk_i(link_clk),
        .async_i({reset_i, run_src}),
        .sync_o(to_link)
    );

    assign link_rst = to_link[1];
    assign link_run = to_link[0];
    assign active = link_run & ~frame_n_i;

    // bit counter wraps after the 16th edge
    always_ff @(posedge link_clk) begin
        if (link_rst || frame_n_i) begin
            count_reg <= 4'h0;
        end else if (link_run) begin
            count_reg <= count_reg + 4'h1;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            shift_reg <= 16'h0000;
        end else if (active) begin
            shift_reg <= shift_next;
        end
    end

    assign shift_next = {shift_reg[14:0], din_i};
    assign ctrl_word = shift_next[11:0];
    assign ctrl_edge = active && count_reg == `ACS_CNT_CTRL_DONE;
    assign frame_end = active && count_reg == `ACS_CNT_LAST;

    // a mask frame carries no control word
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ctrl_reg <= `ACS_CTL_RESET;
        end else if (ctrl_edge && ctrl_word[`ACS_CTL_WRITE] && seq_reg != acs_pkg::SEQ_LOAD_MASK) begin
            ctrl_reg <= ctrl_word;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst || frame_n_i) begin
            wrote_reg <= 1'b0;
        end else if (ctrl_edge) begin
            wrote_reg <= ctrl_word[`ACS_CTL_WRITE] && seq_reg != acs_pkg::SEQ_LOAD_MASK;
        end
    end

    assign addr = ctrl_reg[`ACS_CTL_ADDR_HI:`ACS_CTL_ADDR_LO];
    assign mode = acs_pkg::acs_mode_t'({ctrl_reg[`ACS_CTL_AUTO], ctrl_reg[`ACS_CTL_SHADOW]});

    // first bit shifted in belongs to channel 0
    for (genvar i = 0; i < CHANNELS; i++) begin : g_rev
        assign mask_in[i] = shift_next[CHANNELS-1-i];
    end

    // next set channel above cur, else the lowest set one
    function automatic logic [3:0] acs_next_chan(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] first;
        logic [3:0] above;
        logic got;
        first = 4'h0;
        above = 4'h0;
        got = 1'b0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                first = 4'(i);
                if (4'(i) > cur) begin
                    above = 4'(i);
                    got = 1'b1;
                end
            end
        end
        return got ? above : first;
    endfunction : acs_next_chan

    always_comb begin
        unique case (seq_reg)
            acs_pkg::SEQ_MASK: step_chan = acs_next_chan(mask_reg, chan_reg);
            acs_pkg::SEQ_CONSEC: step_chan = (chan_reg == addr) ? 4'h0 : chan_reg + 4'h1;
            acs_pkg::SEQ_OFF, acs_pkg::SEQ_LOAD_MASK: step_chan = chan_reg;
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            mask_reg <= `ACS_MASK_RESET;
        end else if (frame_end && seq_reg == acs_pkg::SEQ_LOAD_MASK) begin
            mask_reg <= mask_in;
        end
    end

    // next channel is settled at frame end, before the next frame opens
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            seq_reg <= acs_pkg::SEQ_OFF;
            chan_reg <= 4'h0;
        end else if (frame_end) begin
            if (seq_reg == acs_pkg::SEQ_LOAD_MASK) begin
                if (mask_in == 16'h0000) begin
                    seq_reg <= acs_pkg::SEQ_OFF;
                    chan_reg <= addr;
                end else begin
                    seq_reg <= acs_pkg::SEQ_MASK;
                    chan_reg <= acs_next_chan(mask_in, 4'hF);
                end
            end else if (wrote_reg) begin
                unique case (mode)
                    acs_pkg::MODE_PLAIN: begin
                        seq_reg <= acs_pkg::SEQ_OFF;
                        chan_reg <= addr;
                    end
                    acs_pkg::MODE_MASK_NEXT: begin
                        seq_reg <= acs_pkg::SEQ_LOAD_MASK;
                        chan_reg <= addr;
                    end
                    acs_pkg::MODE_KEEP: begin
                        // outside a sequence this acts as a plain write
                        chan_reg <= (seq_reg == acs_pkg::SEQ_OFF) ? addr : step_chan;
                    end
                    acs_pkg::MODE_CONSEC: begin
                        seq_reg <= acs_pkg::SEQ_CONSEC;
                        chan_reg <= 4'h0;
                    end
                endcase
            end else begin
                chan_reg <= step_chan;
            end
        end
    end

    assign sar_start = active && count_reg == `ACS_CNT_SAR_START;
    assign sar_step = active && count_reg > `ACS_CNT_SAR_START && count_reg <= `ACS_CNT_SAR_LAST;

    // range and coding fixed per conversion; a control write lands mid-frame
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            conv_cfg_reg <= `ACS_CONV_RESET;
        end else if (sar_start) begin
            conv_cfg_reg <= {ctrl_reg[`ACS_CTL_RANGE], ctrl_reg[`ACS_CTL_CODING]};
        end
    end

    acs_sar #(
        .BITS(DATA_BITS)
    ) u_sar (
        .clk_i(link_clk),
        .rst_i(link_rst),
        .en_i(link_run),
        .start_i(sar_start),
        .step_i(sar_step),
        .comp_i(comp_i),
        .code_o(code)
    );

    assign coded = conv_cfg_reg[0] ? code : code ^ `ACS_MSB_FLIP;
    assign out_word = {chan_reg, coded};
    // each result bit resolves one edge before it is shown
    assign dout_o = out_word[4'hF - count_reg];
    assign dout_oe_n_o = ~active;
    assign hold_o = active && count_reg < `ACS_CNT_HOLD_END;
    assign mux_sel_o = chan_reg;
    assign dac_code_o = code;
    assign span_double_o = ~conv_cfg_reg[1];
    assign power_mode_o = ctrl_reg[`ACS_CTL_PM_HI:`ACS_CTL_PM_LO];

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            word_hold_reg <= 16'h0000;
            tog_reg <= 1'b0;
        end else if (frame_end) begin
            word_hold_reg <= out_word;
            tog_reg <= ~tog_reg;
        end
    end

    acs_sync2 #(
        .WIDTH(1)
    ) u_to_sys (
        .clk_i(sys_clk_i),
        .async_i(tog_reg),
        .sync_o(tog_s)
    );

    // held words stay still for a whole frame after the toggle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tog_seen_reg <= 1'b0;
            res_reg <= 16'h0000;
            ctrl_s_reg <= `ACS_CTL_RESET;
            mask_s_reg <= `ACS_MASK_RESET;
            seq_s_reg <= 2'h0;
            frames_reg <= 16'h0000;
        end else if (ce_i) begin
            tog_seen_reg <= tog_s;
            if (tog_s != tog_seen_reg) begin
                res_reg <= word_hold_reg;
                ctrl_s_reg <= ctrl_reg;
                mask_s_reg <= mask_reg;
                seq_s_reg <= seq_reg;
                frames_reg <= frames_reg + 16'h0001;
            end
        end
    end

    function automatic logic [31:0] acs_read(input logic [4:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `ACS_REG_CFG: d[0] = cfg_en_reg;
            `ACS_REG_RESULT: d[15:0] = res_reg;
            `ACS_REG_CTRL: d[11:0] = ctrl_s_reg;
            `ACS_REG_MASK: d[15:0] = mask_s_reg;
            `ACS_REG_STATUS: d = {frames_reg, 14'h0000, seq_s_reg};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : acs_read

    assign req = avs_read_i | avs_write_i;
    // a frozen cycle must not look like an answer
    assign avs_waitrequest_o = req & ~(ack_reg & ce_i);
    assign avs_readdata_o = rdata_reg;

    // every access answers on its second clock-enabled cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= req & ~ack_reg;
            if (avs_read_i && !ack_reg) begin
                rdata_reg <= acs_read(avs_address_i);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cfg_en_reg <= `ACS_CFG_RESET;
        end else if (ce_i && avs_write_i && ack_reg && avs_address_i == `ACS_REG_CFG
                     && avs_byteenable_i[0]) begin
            cfg_en_reg <= avs_writedata_i[`ACS_CFG_EN_BIT];
        end
    end

    ctrl_upd_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            ctrl_edge && ctrl_word[`ACS_CTL_WRITE] && seq_reg != acs_pkg::SEQ_LOAD_MASK
            |=> ctrl_reg == $past(ctrl_word))
        else $error("control word not loaded");

    ctrl_keep_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            ctrl_edge && !ctrl_word[`ACS_CTL_WRITE] |=> $stable(ctrl_reg))
        else $error("control changed without write bit");

    mask_load_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && seq_reg == acs_pkg::SEQ_LOAD_MASK |=> mask_reg == $past(mask_in))
        else $error("channel mask not loaded");

    mask_first_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && seq_reg == acs_pkg::SEQ_LOAD_MASK && mask_in[0]
            |=> seq_reg == acs_pkg::SEQ_MASK && chan_reg == 4'h0)
        else $error("mask sequence did not start at lowest channel");

    mask_member_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && seq_reg == acs_pkg::SEQ_MASK && !wrote_reg |=> mask_reg[chan_reg])
        else $error("sequence left the mask");

    consec_wrap_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && seq_reg == acs_pkg::SEQ_CONSEC && !wrote_reg && chan_reg == addr
            |=> chan_reg == 4'h0)
        else $error("consecutive run did not restart at channel 0");

    consec_step_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && seq_reg == acs_pkg::SEQ_CONSEC && !wrote_reg && chan_reg != addr
            |=> chan_reg == $past(chan_reg) + 4'h1)
        else $error("consecutive run skipped a channel");

    keep_seq_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && wrote_reg && mode == acs_pkg::MODE_KEEP && seq_reg == acs_pkg::SEQ_MASK
            |=> seq_reg == acs_pkg::SEQ_MASK)
        else $error("keep write stopped the sequence");

    plain_sel_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && wrote_reg && mode == acs_pkg::MODE_PLAIN
            |=> seq_reg == acs_pkg::SEQ_OFF && mux_sel_o == $past(addr))
        else $error("plain write did not select its channel");

    tag_word_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end |=> word_hold_reg[15:12] == $past(chan_reg))
        else $error("word tag is not the converted channel");

    twos_code_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            frame_end && !conv_cfg_reg[0] |=> word_hold_reg[11] == !$past(code[11]))
        else $error("twos complement sign wrong");

    tag_first_a:
        assert property (@(posedge link_clk) disable iff (link_rst)
            active && count_reg == 4'h0 |-> !dout_oe_n_o && dout_o == chan_reg[3])
        else $error("first bit out is not tag msb");

    bus_answer_a:
        assert property (@(posedge sys_clk_i) disable iff (reset_i)
            ce_i && req && avs_waitrequest_o ##1 ce_i |-> !avs_waitrequest_o)
        else $error("bus answer later than one wait cycle");
endmodule : acs_adc_seq

// ### bench/acs_host_model.sv
`timescale 1ns/10ps

module acs_host_model (
    output logic sclk_o,
    output logic frame_n_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic dout_oe_n_i
);
    logic oe_low;

    // serial clock stands high between frames
    initial begin
        sclk_o = 1'b1;
        frame_n_o = 1'b1;
        din_o = 1'b0;
        oe_low = 1'b0;
    end

    // frame select high: link reset and enable sync see edges
    task automatic burst(input int n);
        repeat (n) begin
            #24 sclk_o = 1'b0;
            #24 sclk_o = 1'b1;
        end
    endtask : burst

    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        frame_n_o = 1'b0;
        din_o = tx[15]; // msb first
        oe_low = 1'b0;
        #24;
        for (int i = 15; i >= 0; i--) begin // exactly 16 falling edges
            rx[i] = dout_i;
            if (dout_oe_n_i === 1'b0) begin
                oe_low = 1'b1;
            end
            sclk_o = 1'b0;
            #24;
            sclk_o = 1'b1;
            // released data line shows the inverse, never a stale level
            din_o = (i > 0) ? tx[i-1] : ~tx[0];
            #24;
        end
        frame_n_o = 1'b1;
        #48;
    endtask : frame
endmodule : acs_host_model

// ### bench/tb.sv
`timescale 1ns/10ps
`include "acs_map.svh"

module tb;
    logic sys_clk, reset, avs_read, avs_write, waitreq, sclk, frame_n, din, dout, dout_oe_n, comp, span_dbl, hold;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic [3:0] mux_sel;
    logic [11:0] dac_code;
    logic [1:0] power_mode;
    logic [15:0] rx, tx, pend;
    logic rng, cod, ce;
    logic [3:0] be;
    logic [3:0] pch [6] = '{4'h3, 4'hF, 4'hF, 4'h0, 4'h9, 4'hF};
    logic [5:0] pr = 6'h15;
    logic [5:0] pc = 6'h2D;
    logic [3:0] mch [5] = '{4'h2, 4'h5, 4'h9, 4'h2, 4'h5};
    int miscompares = 0;
    int comparisons = 0;

    acs_adc_seq i_dut (.sys_clk_i(sys_clk), .reset_i(reset), .ce_i(ce), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(be), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(waitreq),
        .sclk_i(sclk), .frame_n_i(frame_n), .din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n),
        .comp_i(comp), .mux_sel_o(mux_sel), .dac_code_o(dac_code), .span_double_o(span_dbl),
        .hold_o(hold), .power_mode_o(power_mode));

    acs_host_model i_host (.sclk_o(sclk), .frame_n_o(frame_n), .din_o(din), .dout_i(dout),
        .dout_oe_n_i(dout_oe_n));

    // input in mV, reference 2500 mV; channel 15 sits exactly on the reference
    function automatic int vin(input logic [3:0] c);
        return 100 + 160 * c;
    endfunction : vin

    assign comp = (vin(mux_sel) * 4096) >= (int'(dac_code) * 2500 * (span_dbl ? 2 : 1));

    function automatic logic [15:0] ew(input logic [3:0] c);
        int v;
        logic [11:0] k;
        v = vin(c) * 4096 / (2500 * (rng ? 1 : 2));
        k = (v > 4095) ? 12'hFFF : v[11:0];
        if (!cod) begin
            k[11] = ~k[11];
        end
        return {c, k};
    endfunction : ew

    function automatic logic [15:0] cw(input logic w, input logic a, input logic [3:0] c, input logic s);
        return {w, a, c, 2'h3, s, 1'b0, rng, cod, 4'h0};
    endfunction : cw

    task summarize;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_reg

    task chk_word(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word

    // request held until waitrequest seen low, released after that edge
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        @(posedge sys_clk);
        while (waitreq !== 1'b0 && n < 64) begin
            @(posedge sys_clk);
            n++;
        end
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) begin
            miscompares++;
            summarize();
        end
    endtask : av

    task xf(input logic [15:0] t, input logic [15:0] e);
        i_host.frame(t, rx);
        chk_word(rx, e);
    endtask : xf

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        ce = 1'b1;
        be = 4'hF;
        rng = 1'b1;
        cod = 1'b1;
        // reset spans a link burst so the synced link reset lands
        i_host.burst(4);
        @(posedge sys_clk);
        reset <= 1'b0;
        i_host.burst(4);
        av(1'b0, `ACS_REG_CFG, 32'h0);
        chk_reg(rdat, 32'h00000001);
        av(1'b0, `ACS_REG_STATUS, 32'h0);
        chk_reg(rdat, 32'h00000000);
        av(1'b1, 5'h14, 32'hFFFFFFFF);
        av(1'b0, 5'h14, 32'h0);
        chk_reg(rdat, 32'h00000000);
        av(1'b1, `ACS_REG_CTRL, 32'hFFFFFFFF);
        av(1'b0, `ACS_REG_CTRL, 32'h0);
        chk_reg(rdat, 32'h00000000);
        av(1'b1, `ACS_REG_CFG, 32'h00000000);
        av(1'b0, `ACS_REG_CFG, 32'h0);
        chk_reg(rdat, 32'h00000000);
        i_host.burst(4);
        i_host.frame(cw(1'b1, 1'b0, 4'h5, 1'b0), rx);
        chk_word({15'h0, i_host.oe_low}, 16'h0000);
        av(1'b1, `ACS_REG_CFG, 32'h00000001);
        i_host.burst(4);
        av(1'b0, `ACS_REG_CTRL, 32'h0);
        chk_reg(rdat, 32'h00000000);
        // cfg write without byte 0 is dropped
        be <= 4'hE;
        av(1'b1, `ACS_REG_CFG, 32'h00000000);
        be <= 4'hF;
        av(1'b0, `ACS_REG_CFG, 32'h0);
        chk_reg(rdat, 32'h00000001);
        // clock enable low: link frozen, pin never driven
        @(posedge sys_clk);
        ce <= 1'b0;
        i_host.burst(4);
        i_host.frame(cw(1'b1, 1'b0, 4'h5, 1'b0), rx);
        chk_word({15'h0, i_host.oe_low}, 16'h0000);
        @(posedge sys_clk);
        ce <= 1'b1;
        i_host.burst(4);
        // plain channel select across ranges and codings; last frame has write low
        for (int i = 0; i < 7; i++) begin
            if (i < 6) begin
                rng = pr[i];
                cod = pc[i];
                tx = cw(1'b1, 1'b0, pch[i], 1'b0);
            end else begin
                tx = 16'h7FFF;
            end
            i_host.frame(tx, rx);
            if (i > 0) chk_word(rx, pend);
            if (i < 6) pend = ew(pch[i]);
        end
        xf(16'h0000, pend);
        chk_word({15'h0, i_host.oe_low}, 16'h0001);
        av(1'b0, `ACS_REG_RESULT, 32'h0);
        chk_reg(rdat, {16'h0, pend});
        av(1'b0, `ACS_REG_CTRL, 32'h0);
        chk_reg(rdat, 32'h00000BF1);
        chk_word({13'h0, hold, power_mode}, 16'h0003);
        // mask sequence over channels 2, 5, 9
        rng = 1'b1;
        cod = 1'b1;
        i_host.frame(cw(1'b1, 1'b0, 4'h1, 1'b1), rx);
        i_host.frame(16'h2440, rx);
        for (int k = 0; k < 5; k++) begin
            xf(16'h0000, ew(mch[k]));
        end
        av(1'b0, `ACS_REG_MASK, 32'h0);
        chk_reg(rdat, 32'h00000224);
        av(1'b0, `ACS_REG_STATUS, 32'h0);
        chk_reg({30'h0, rdat[1:0]}, 32'h00000002);
        pend = ew(4'h9);
        rng = 1'b0;
        i_host.frame(cw(1'b1, 1'b1, 4'h0, 1'b0), rx);
        chk_word(rx, pend);
        xf(16'h0000, ew(4'h2));
        pend = ew(4'h5);
        i_host.frame(cw(1'b1, 1'b0, 4'h7, 1'b0), rx);
        chk_word(rx, pend);
        xf(16'h0000, ew(4'h7));
        av(1'b0, `ACS_REG_STATUS, 32'h0);
        chk_reg({30'h0, rdat[1:0]}, 32'h00000000);
        // consecutive run 0..3 with a keep-mode write in the middle
        i_host.frame(cw(1'b1, 1'b1, 4'h3, 1'b1), rx);
        chk_word(rx, ew(4'h7));
        for (int k = 0; k < 6; k++) begin
            tx = (k == 2) ? cw(1'b1, 1'b1, 4'h3, 1'b0) : 16'h0000;
            xf(tx, ew(k[3:0] % 4'h4));
        end
        av(1'b0, `ACS_REG_STATUS, 32'h0);
        chk_reg(rdat, 32'h001A0003);
        summarize();
    end
endmodule : tb
